// ---- src/rtc_pkg.sv ----
// Constants shared by the clock unit control block and its timer core.
// Assumes a 10 MHz bus clock and a slow oscillator output on a pin.
//
// How it works
// - Oscillator enable bit 7 drives oscillator and bias enable output.
// - Bit 6 switches the missing-clock detector on or off.
// - Detector firing sets fail flag bit 5; software writes 0 to clear.
// - Run bit 4 lets the timer count; cleared, it holds value.
// - Alarm enable bit 3 gates alarms; clearing it drops the alarm flag.
// - Reading bit 2 returns the alarm event flag.
// - Writing bit 2 sets auto-reset enable, never the alarm flag.
// - Writing 1 to bit 1 loads the timer; bit clears when done.
// - Writing 1 to bit 0 snapshots the timer; bit clears when done.
// - Alarm flag lasts at most one slow cycle while the timer runs, then drops itself.
// - The 32-bit timer adds one each slow cycle while running.
// - Oscillator level held over 100 us sets the fail flag.
// - Alarm event raised when timer equals the 32-bit match value.
// - Auto-reset zeroes timer one slow cycle after alarm drops.
package rtc_pkg;
  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_CAPTURE0  = 6'h00;
  localparam logic [5:0] IDX_CTRL      = 6'h04;
  localparam logic [5:0] IDX_MATCH0    = 6'h08;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h0C;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h0D;
  localparam int         BYTE_REGS     = 4;
  // Control register fields
  localparam int BIT_OSC_EN   = 7;
  localparam int BIT_MCD_EN   = 6;
  localparam int BIT_FAIL     = 5;
  localparam int BIT_RUN      = 4;
  localparam int BIT_ALARM_EN = 3;
  localparam int BIT_ALARM    = 2;
  localparam int BIT_LOAD     = 1;
  localparam int BIT_SNAP     = 0;
  // Interrupt status and mask fields
  localparam int IRQ_ALARM    = 0;
  localparam int IRQ_FAIL     = 1;
  localparam int IRQ_BITS     = 2;
  // Reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // Timing of the missing-clock detector
  localparam int CLK_PERIOD_NS = 100;
  localparam int MCD_TIME_NS   = 100_000;
  localparam int MCD_CYCLES    = MCD_TIME_NS / CLK_PERIOD_NS;
  localparam int MCD_CNT_W     = $clog2(MCD_CYCLES + 2);
endpackage : rtc_pkg

// ---- src/timer_if.sv ----
// Signals between the control block and the slow-cycle timer core.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic        tick;
  logic        run;
  logic        alarm_en;
  logic        autoreset;
  logic        load_req;
  logic        snap_req;
  logic [31:0] load_val;
  logic [31:0] match_val;
  logic [31:0] snap_val;
  logic        load_done;
  logic        snap_done;
  logic        alarm;
  modport core (input tick, run, alarm_en, autoreset, load_req, snap_req,
                input load_val, match_val,
                output snap_val, load_done, snap_done, alarm);
  modport ctrl (output tick, run, alarm_en, autoreset, load_req, snap_req,
                output load_val, match_val,
                input snap_val, load_done, snap_done, alarm);
endinterface : timer_if
`default_nettype wire

// ---- src/rtc_timer_core.sv ----
// Timer core: 32-bit counter, alarm compare, auto-reset, load, snapshot.
// Assumes tick is a one-cycle pulse per slow oscillator cycle.
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_core
(
  input  wire logic clk,
  input  wire logic reset_n,
  timer_if.core     tif
);
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic        alarm_reg;
  logic        alarm_next;
  logic        clr_pend_reg;
  logic        clr_pend_next;
  logic [31:0] snap_reg;
  logic        load_done_reg;
  logic        snap_done_reg;
  logic        hit;

  // ***************************************************************
  // Next-state selection
  // ***************************************************************
  // Compare and timer update
  assign hit = tif.alarm_en && (timer_reg == tif.match_val);
  assign timer_next = tif.load_req ? tif.load_val :
                      clr_pend_reg ? 32'h0000_0000 :
                      tif.run      ? timer_reg + 32'h0000_0001
                                   : timer_reg;
  // Flag lives one slow cycle at most while the timer runs
  assign alarm_next = !tif.alarm_en ? 1'b0 :
                      tif.tick ? hit : alarm_reg;
  assign clr_pend_next = tif.tick
                       ? (tif.autoreset && alarm_reg)
                       : clr_pend_reg;

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Counter and alarm state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_reg    <= rtc_pkg::WORD_RESET;
      alarm_reg    <= 1'b0;
      clr_pend_reg <= 1'b0;
    end
    else
    begin
      if (tif.tick)
        timer_reg <= timer_next;
      alarm_reg    <= alarm_next;
      clr_pend_reg <= clr_pend_next;
    end
  end

  // Snapshot and completion pulses
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      snap_reg      <= rtc_pkg::WORD_RESET;
      load_done_reg <= 1'b0;
      snap_done_reg <= 1'b0;
    end
    else
    begin
      load_done_reg <= tif.tick && tif.load_req;
      snap_done_reg <= tif.tick && tif.snap_req;
      if (tif.tick && tif.snap_req)
        snap_reg <= timer_reg;
    end
  end

  assign tif.snap_val  = snap_reg;
  assign tif.load_done = load_done_reg;
  assign tif.snap_done = snap_done_reg;
  assign tif.alarm     = alarm_reg;
endmodule : rtc_timer_core
`default_nettype wire

// ---- src/rtc_control.sv ----
// Clock unit control block with APB slave, detector and interrupts.
// Assumes osc_in is the raw slow oscillator pin, asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rtc_control
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              osc_in,
  output var  logic              osc_enable,
  output var  logic              mcd_enable,
  output var  logic              alarm_event,
  output var  logic              irq
);
  // ***************************************************************
  // Parameter check
  // ***************************************************************
  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  timer_if tif ();

  logic                        osc_meta_reg;
  logic                        osc_sync_reg;
  logic                        osc_prev_reg;
  logic                        osc_edge;
  logic [rtc_pkg::MCD_CNT_W-1:0] mcd_cnt_reg;
  logic [rtc_pkg::MCD_CNT_W-1:0] mcd_cnt_next;
  logic                        mcd_fire;
  logic [7:0]                  ctrl_reg;
  logic [7:0]                  ctrl_next;
  logic [31:0]                 capture_reg;
  logic [31:0]                 capture_next;
  logic [31:0]                 match_reg;
  logic [31:0]                 match_next;
  logic [rtc_pkg::IRQ_BITS-1:0] stat_reg;
  logic [rtc_pkg::IRQ_BITS-1:0] stat_next;
  logic [rtc_pkg::IRQ_BITS-1:0] mask_reg;
  logic [rtc_pkg::IRQ_BITS-1:0] mask_next;
  logic [rtc_pkg::IRQ_BITS-1:0] events;
  logic                        alarm_prev_reg;
  logic [31:0]                 prdata_reg;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic                        irq_reg;
  logic                        osc_en_reg;
  logic                        mcd_en_reg;
  logic                        alarm_out_reg;
  logic [5:0]                  idx;
  logic                        aligned;
  logic                        hit_ctrl;
  logic                        hit_cap;
  logic                        hit_match;
  logic                        hit_stat;
  logic                        hit_mask;
  logic                        mapped;
  logic                        access;
  logic                        wr_en;
  logic [1:0]                  byte_sel;
  logic [7:0]                  wbyte;
  logic [7:0]                  ctrl_rd;
  logic [31:0]                 rd_data;
  logic                        fail_next;

  // ***************************************************************
  // Oscillator pin synchroniser and edge detect
  // ***************************************************************
  // Two flops before use, third for edge history
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      osc_meta_reg <= osc_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // Any transition re-arms the detector; rising edge is the slow tick
  assign osc_edge = osc_sync_reg ^ osc_prev_reg;
  assign tif.tick = osc_sync_reg & ~osc_prev_reg;

  // ***************************************************************
  // Missing-clock detector
  // ***************************************************************
  // One-shot: counts idle cycles, fires once, holds until an edge
  assign mcd_cnt_next =
    (!ctrl_reg[rtc_pkg::BIT_MCD_EN] || osc_edge)
      ? '0
      : (mcd_cnt_reg == rtc_pkg::MCD_CNT_W'(rtc_pkg::MCD_CYCLES + 1))
        ? mcd_cnt_reg
        : mcd_cnt_reg + rtc_pkg::MCD_CNT_W'(1);
  assign mcd_fire = ctrl_reg[rtc_pkg::BIT_MCD_EN] && !osc_edge &&
    (mcd_cnt_reg == rtc_pkg::MCD_CNT_W'(rtc_pkg::MCD_CYCLES));

  // Detector counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mcd_cnt_reg <= '0;
    else
      mcd_cnt_reg <= mcd_cnt_next;
  end

  // ***************************************************************
  // APB address decode
  // ***************************************************************
  // Word index and register hits
  assign idx       = paddr[7:2];
  assign aligned   = (paddr[1:0] == 2'b00) &&
                     (paddr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  assign hit_ctrl  = aligned && (idx == rtc_pkg::IDX_CTRL);
  assign hit_cap   = aligned && (idx[5:2] == rtc_pkg::IDX_CAPTURE0[5:2]);
  assign hit_match = aligned && (idx[5:2] == rtc_pkg::IDX_MATCH0[5:2]);
  assign hit_stat  = aligned && (idx == rtc_pkg::IDX_IRQ_STAT);
  assign hit_mask  = aligned && (idx == rtc_pkg::IDX_IRQ_MASK);
  assign mapped    = hit_ctrl | hit_cap | hit_match | hit_stat | hit_mask;
  assign byte_sel  = idx[1:0];
  assign wbyte     = pwdata[7:0];

  // One wait state, write lands on the edge pready is sampled
  assign access = psel && penable && !pready_reg;
  assign wr_en  = psel && penable && pready_reg && pwrite && mapped;

  // ***************************************************************
  // Control register
  // ***************************************************************
  // Fail flag: hardware set wins over a software clear
  assign fail_next = mcd_fire ||
    ((wr_en && hit_ctrl) ? (ctrl_reg[rtc_pkg::BIT_FAIL] &
                            wbyte[rtc_pkg::BIT_FAIL])
                         : ctrl_reg[rtc_pkg::BIT_FAIL]);

  // Next control value
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_en && hit_ctrl)
    begin
      ctrl_next[rtc_pkg::BIT_OSC_EN]   = wbyte[rtc_pkg::BIT_OSC_EN];
      ctrl_next[rtc_pkg::BIT_MCD_EN]   = wbyte[rtc_pkg::BIT_MCD_EN];
      ctrl_next[rtc_pkg::BIT_RUN]      = wbyte[rtc_pkg::BIT_RUN];
      ctrl_next[rtc_pkg::BIT_ALARM_EN] = wbyte[rtc_pkg::BIT_ALARM_EN];
      ctrl_next[rtc_pkg::BIT_ALARM]    = wbyte[rtc_pkg::BIT_ALARM];
      if (wbyte[rtc_pkg::BIT_LOAD])
        ctrl_next[rtc_pkg::BIT_LOAD] = 1'b1;
      if (wbyte[rtc_pkg::BIT_SNAP])
        ctrl_next[rtc_pkg::BIT_SNAP] = 1'b1;
    end
    if (tif.load_done)
      ctrl_next[rtc_pkg::BIT_LOAD] = 1'b0;
    if (tif.snap_done)
      ctrl_next[rtc_pkg::BIT_SNAP] = 1'b0;
    ctrl_next[rtc_pkg::BIT_FAIL] = fail_next;
  end

  // Bit 2 stores auto-reset; reads show the alarm flag instead
  always_comb
  begin
    ctrl_rd = ctrl_reg;
    ctrl_rd[rtc_pkg::BIT_ALARM] = tif.alarm;
  end

  // Control state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= rtc_pkg::CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  // ***************************************************************
  // Capture and match bytes
  // ***************************************************************
  // Byte writes; a finished snapshot overrides the capture bytes
  for (genvar b = 0; b < rtc_pkg::BYTE_REGS; b++)
  begin : g_bytes
    assign capture_next[8*b +: 8] =
      tif.snap_done ? tif.snap_val[8*b +: 8] :
      (wr_en && hit_cap && byte_sel == 2'(b)) ? wbyte :
      capture_reg[8*b +: 8];
    assign match_next[8*b +: 8] =
      (wr_en && hit_match && byte_sel == 2'(b)) ? wbyte :
      match_reg[8*b +: 8];
  end

  // Byte register state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      capture_reg <= rtc_pkg::WORD_RESET;
      match_reg   <= rtc_pkg::WORD_RESET;
    end
    else
    begin
      capture_reg <= capture_next;
      match_reg   <= match_next;
    end
  end

  // ***************************************************************
  // Timer core
  // ***************************************************************
  // Steering from the control bits
  assign tif.run       = ctrl_reg[rtc_pkg::BIT_RUN];
  assign tif.alarm_en  = ctrl_reg[rtc_pkg::BIT_ALARM_EN];
  assign tif.autoreset = ctrl_reg[rtc_pkg::BIT_ALARM];
  assign tif.load_req  = ctrl_reg[rtc_pkg::BIT_LOAD];
  assign tif.snap_req  = ctrl_reg[rtc_pkg::BIT_SNAP];
  assign tif.load_val  = capture_reg;
  assign tif.match_val = match_reg;

  rtc_timer_core u_core
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  // Events: alarm rising, detector firing
  assign events[rtc_pkg::IRQ_ALARM] = tif.alarm && !alarm_prev_reg;
  assign events[rtc_pkg::IRQ_FAIL]  = mcd_fire;
  // Write one to clear, a new event wins
  assign stat_next = events |
    (stat_reg & ~((wr_en && hit_stat)
                  ? pwdata[rtc_pkg::IRQ_BITS-1:0]
                  : '0));
  assign mask_next = (wr_en && hit_mask)
                   ? pwdata[rtc_pkg::IRQ_BITS-1:0]
                   : mask_reg;

  // Status, mask and output level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_reg       <= '0;
      mask_reg       <= '0;
      alarm_prev_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end
    else
    begin
      stat_reg       <= stat_next;
      mask_reg       <= mask_next;
      alarm_prev_reg <= tif.alarm;
      irq_reg        <= |(stat_next & mask_next);
    end
  end

  // ***************************************************************
  // Read mux and APB answer
  // ***************************************************************
  // Unmapped reads return zero
  assign rd_data =
    hit_ctrl  ? {24'h00_0000, ctrl_rd} :
    hit_cap   ? {24'h00_0000, capture_reg[8*byte_sel +: 8]} :
    hit_match ? {24'h00_0000, match_reg[8*byte_sel +: 8]} :
    hit_stat  ? {30'h0000_0000, stat_reg} :
    hit_mask  ? {30'h0000_0000, mask_reg} :
                32'h0000_0000;

  // Answer registered one cycle into the access phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= rtc_pkg::WORD_RESET;
    end
    else
    begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg  <= (access && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Analog enables and event output
  // ***************************************************************
  // Registered copies for the pins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_en_reg    <= 1'b0;
      mcd_en_reg    <= 1'b0;
      alarm_out_reg <= 1'b0;
    end
    else
    begin
      osc_en_reg    <= ctrl_next[rtc_pkg::BIT_OSC_EN];
      mcd_en_reg    <= ctrl_next[rtc_pkg::BIT_MCD_EN];
      alarm_out_reg <= tif.alarm;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign osc_enable  = osc_en_reg;
  assign mcd_enable  = mcd_en_reg;
  assign alarm_event = alarm_out_reg;
  assign irq         = irq_reg;
endmodule : rtc_control
`default_nettype wire

// ---- testbench/rtc_control_checker.sv ----
// Port-level checks for the clock unit control block.
// Assumes it is bound into rtc_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtc_control_checker
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              osc_in,
  input wire logic              osc_enable,
  input wire logic              mcd_enable,
  input wire logic              alarm_event,
  input wire logic              irq
);
  //**************************************************************
  // Helper state
  //**************************************************************
  logic [7:0] ctl_q;
  logic [2:0] osc_s;
  logic [3:0] quiet;
  logic [1:0] hi_cnt;
  logic [1:0] wait_q;
  wire logic  ctl_hit;
  wire logic  osc_rise;

  // Finished control access and synchronised slow edge
  assign ctl_hit  = psel && penable && pready && paddr == ADDR_W'(8'h10);
  assign osc_rise = osc_s[1] && !osc_s[2];

  // Last control write, slow-pin history and quiet time
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ctl_q <= 8'h00;
      osc_s <= 3'h0;
      quiet <= 4'h0;
    end
    else
    begin
      ctl_q <= (ctl_hit && pwrite) ? pwdata[7:0] : ctl_q;
      osc_s <= {osc_s[1:0], osc_in};
      quiet <= (osc_in != osc_s[0]) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end

  // Slow edges under a high alarm; requests not yet met by an edge
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      hi_cnt <= 2'h0;
      wait_q <= 2'h0;
    end
    else
    begin
      hi_cnt <= alarm_event ? hi_cnt + {1'b0, osc_rise && hi_cnt != 2'h3}
                            : 2'h0;
      wait_q <= osc_in ? 2'h0
                       : wait_q | ((ctl_hit && pwrite) ? pwdata[1:0] : 2'h0);
    end

  //**************************************************************
  // Assertions
  //**************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_ctl_wr;
    ctl_hit && pwrite;
  endsequence
  sequence s_ctl_rd;
    ctl_hit && !pwrite;
  endsequence

  AST_OSC_EN:
    assert property (s_ctl_wr |-> ##2 osc_enable == ctl_q[7])
    else $error("Oscillator enable does not follow bit 7");
  AST_MCD_EN:
    assert property (s_ctl_wr |-> ##2 mcd_enable == ctl_q[6])
    else $error("Detector enable does not follow bit 6");
  AST_ALARM_OFF:
    assert property (s_ctl_wr ##0 !pwdata[3] |-> ##3 !alarm_event [*3])
    else $error("Alarm stays up after alarms were disabled");
  AST_WR_NO_FLAG:
    assert property (s_ctl_wr ##0 (!alarm_event && quiet > 4'h6)
                     |=> !alarm_event [*2])
    else $error("Control write raised the alarm");
  AST_FLAG_READ:
    assert property (s_ctl_rd ##0 quiet > 4'h6 |-> prdata[2] == alarm_event)
    else $error("Bit 2 read differs from the alarm");
  AST_LOAD_HOLD:
    assert property (s_ctl_rd ##0 wait_q[1] |-> prdata[1])
    else $error("Load bit cleared before a slow edge");
  AST_SNAP_HOLD:
    assert property (s_ctl_rd ##0 wait_q[0] |-> prdata[0])
    else $error("Snapshot bit cleared before a slow edge");
  AST_ALARM_SHORT:
    assert property (alarm_event |-> hi_cnt < 2'h2)
    else $error("Alarm held over a whole slow cycle");
endmodule : rtc_control_checker

bind rtc_control rtc_control_checker #(.ADDR_W(ADDR_W)) u_checker (
  .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
  .osc_enable(osc_enable), .mcd_enable(mcd_enable),
  .alarm_event(alarm_event), .irq(irq));
`default_nettype wire

// ---- testbench/test_rtc_control.sv ----
// Self-checking bench for the clock unit control block.
// Assumes rtc_control and its bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_rtc_control;
  //**************************************************************
  // Signals and model
  //**************************************************************
  logic        clk;
  logic        reset_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_in;
  logic        osc_enable;
  logic        mcd_enable;
  logic        alarm_event;
  logic        irq;
  logic [31:0] seed;
  logic [31:0] r;
  logic        err;
  logic [7:0]  ctl_w;
  int unsigned tmr, cap, mat;
  bit          run, aen, ar, flag, arm, ld, sn, fail;
  int          n_fail;
  int          tests_run;

  rtc_control #(.ADDR_W(8)) dut (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
    .osc_enable(osc_enable), .mcd_enable(mcd_enable),
    .alarm_event(alarm_event), .irq(irq));

  // Bus clock, 100 ns period
  always #50 clk = ~clk;

  //**************************************************************
  // Tasks
  //**************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Word and bit comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] ectl();
    return {24'h00_0000, ctl_w[7:6], fail, run, aen, flag, ld, sn};
  endfunction : ectl

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk);
    if (n == 20)
    begin
      n_fail++;
      close_out();
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wword(input logic [7:0] base, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      apb(1'b1, base + 8'(4 * i), {24'h00_0000, v[8*i +: 8]}, r);
  endtask : wword

  task automatic wctl(input logic [7:0] v);
    ctl_w = v;
    run   = v[4];
    aen   = v[3];
    ar    = v[2];
    ld    = ld | v[1];
    sn    = sn | v[0];
    fail  = fail & v[5];
    flag  = flag & v[3];
    apb(1'b1, 8'h10, {24'h00_0000, v}, r);
  endtask : wctl

  // One slow oscillator cycle, then the model follows it
  task automatic tick();
    int unsigned old;
    bit          nf;
    osc_in <= 1'b1;
    repeat (5) @(posedge clk);
    osc_in <= 1'b0;
    repeat (6) @(posedge clk);
    old = tmr;
    nf  = aen && old == mat;
    if (ld)
      tmr = cap;
    else if (arm)
      tmr = 0;
    else if (run)
      tmr = tmr + 1;
    if (sn)
      cap = old;
    arm  = ar && flag && !nf;
    flag = nf;
    ld   = 0;
    sn   = 0;
  endtask : tick

  // Request bit stands until a slow edge serves it
  task automatic poll(input int b);
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chkb(r[b], 1'b1);
    for (int n = 0; n < 8 && r[b] !== 1'b0; n++)
    begin
      tick();
      apb(1'b0, 8'h10, 32'h0000_0000, r);
    end
    chkb(r[b], 1'b0);
  endtask : poll

  task automatic rdcap();
    logic [31:0] c;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000, r);
      c[8*i +: 8] = r[7:0];
    end
    chk(c, cap);
  endtask : rdcap

  //**************************************************************
  // Main sequence
  //**************************************************************
  initial
  begin
    {clk, reset_n, psel, penable, pwrite, osc_in} = 6'h00;
    {paddr, pwdata, ctl_w} = 48'h0000_0000_0000;
    seed = 32'h77a9_5edc;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000, r);
    chkb(err, 1'b1);
    apb(1'b1, 8'h11, 32'h0000_00FF, r);
    chkb(err, 1'b1);
    wctl(8'hC0);
    repeat (2) @(posedge clk);
    chk({30'h0, osc_enable, mcd_enable}, 32'h0000_0003);
    wctl(8'h80);
    repeat (2) @(posedge clk);
    chk({30'h0, osc_enable, mcd_enable}, 32'h0000_0002);
    // Load, count, snapshot, then stop
    cap = xs();
    wword(8'h00, cap);
    wctl(8'h92);
    poll(1);
    repeat (xs() % 5 + 2) tick();
    wctl(8'h91);
    poll(0);
    rdcap();
    wctl(8'h80);
    repeat (3) tick();
    wctl(8'h81);
    poll(0);
    rdcap();
    // Alarm with interrupt and auto-reset
    mat = tmr + 2;
    wword(8'h20, mat);
    apb(1'b1, 8'h34, 32'h0000_0001, r);
    wctl(8'h9C);
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    repeat (3) tick();
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    chkb(irq, 1'b1);
    apb(1'b1, 8'h30, 32'h0000_0001, r);
    @(posedge clk);
    chkb(irq, 1'b0);
    tick();
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    chkb(alarm_event, flag);
    tick();
    wctl(8'h9D);
    poll(0);
    rdcap();
    // Disabling alarms drops a raised flag
    mat = tmr;
    wword(8'h20, mat);
    tick();
    chkb(alarm_event, flag);
    wctl(8'h94);
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    apb(1'b1, 8'h30, 32'h0000_0001, r);
    // Missing-clock detector, fail status masked
    wctl(8'hC0);
    tick();
    repeat (880) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    repeat (150) @(posedge clk);
    fail = 1'b1;
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    apb(1'b0, 8'h30, 32'h0000_0000, r);
    chk(r, 32'h0000_0002);
    chkb(irq, 1'b0);
    wctl(8'h80);
    apb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, ectl());
    close_out();
  end
endmodule : test_rtc_control
`default_nettype wire
